// ### rtl/nrfp_pkg.sv
package nrfp_pkg;
	// Timing, clock period in picoseconds
	localparam int CLK_PS      = 5000;
	localparam int OVP_DLY_NS  = 1000;
	localparam int UVP_DLY_NS  = 3000;
	localparam int LOCK_DLY_NS = 3000;
	// Least times round up
	localparam int OVP_CYC  = (OVP_DLY_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int UVP_CYC  = (UVP_DLY_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int LOCK_CYC = (LOCK_DLY_NS * 1000 + CLK_PS - 1) / CLK_PS;

	// Voltages in mV, signed 14 bit
	localparam int MV_W = 14;
	localparam logic signed [13:0] OFS_OFF_MV   = 14'sd300;
	localparam logic signed [13:0] EXT_BASE_MV  = 14'sd1200;
	localparam logic signed [13:0] OVP_FLOOR_MV = 14'sd900;
	localparam logic signed [13:0] OVP_MARG_MV  = 14'sd325;
	localparam logic signed [13:0] UVP_MARG_MV  = 14'sd500;
	localparam logic signed [13:0] NV_LEVEL_MV  = 14'sd0;

	// Current monitor conversion
	localparam logic [21:0] ADC_LSB_UV   = 22'h00186a;
	localparam logic [8:0]  ADC_MAX_CODE = 9'h1ff;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_TIMING = 8'h04;
	localparam logic [7:0] ADDR_INIOFS = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_IOUT   = 8'h10;
	localparam logic [7:0] ADDR_OFFSET = 8'h14;

	// Field positions
	localparam int CTRL_PEAK_LSB = 0;
	localparam int CTRL_PCT_LSB  = 9;
	localparam int TIM_TRIG_LSB  = 0;
	localparam int TIM_ACT_LSB   = 16;
	localparam int STRAP_EXT_BIT = 2;

	// Reset values
	localparam logic [8:0]  RST_PEAK  = 9'h1ff;
	localparam logic [1:0]  RST_PCT   = 2'h0;
	localparam logic [15:0] RST_TRIG  = 16'h00c8;
	localparam logic [15:0] RST_ACT   = 16'h00c8;
	localparam logic [13:0] RST_INIOF = 14'h0000;

	typedef enum logic [1:0] {OC_IDLE, OC_WAIT, OC_SHUT} nrfp_oc_e;

	typedef struct packed {
		logic high;
		logic low;
	} nrfp_gate_s;

	typedef struct packed {
		logic [2:0] one;
		logic [2:0] two;
	} nrfp_strap_s;
endpackage

// ### rtl/nrfp_rail_monitor.sv
`timescale 1ns/1ps
// Operation
// - Offset pin below 0.3V at enable disables initial
// - External offset is pin minus 1.2V plus initial
// - Upward voltage change forces continuous conduction
// - Downward voltage change keeps conduction state
// - Slew compensation bits come from both straps
// - Ramp amplitude comes from strap one
// - Current monitor converted in 6.25mV steps, 511 max
// - Fast transient pulse overrides on-time output
// - Sustained check trips after trigger delay above limit
// - Peak check trips when cycle current exceeds limit
// - Any trip asserts indicator, starts action delay
// - Still high after delay turns all switches off
// - Sustained limit is percentage of peak limit
// - Overvoltage threshold 0.9V floor plus 325mV
// - Overvoltage holds low side on, high off
// - Either latch requests other rail soft shutdown
// - Overvoltage must persist 1us before latching
// - While overvoltage, below 0V turns low side off
// - Above 0V again turns low side back on
// - 500mV under reference for 3us latches undervoltage
// - Supply low for 3us forces all switches off
module nrfp_rail_monitor
	import nrfp_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                ce,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire logic                railEnable,
	input  wire nrfp_strap_s         strapPins,
	input  wire logic signed [13:0]  offsetPinMv,
	input  wire logic signed [13:0]  targetMv,
	input  wire logic signed [13:0]  senseMv,
	input  wire logic [21:0]         currentMonUv,
	input  wire logic                supplyLow,
	input  wire logic                otherRailFault,
	input  wire logic                dvidUp,
	input  wire logic                dvidDown,
	input  wire logic                dvidDone,
	input  wire logic                qrTrigger,
	input  wire logic [7:0]          onTimeLen,
	input  wire logic                onTimeReq,
	input  wire logic                lowSideReq,
	input  wire logic                cycleStart,
	output nrfp_gate_s               gateDrive,
	output logic                     overcurrentIndicator_n,
	output logic                     forceCcm,
	output logic [3:0]               slewCompBits,
	output logic [2:0]               rampSel,
	output logic signed [13:0]       targetOffsetMv,
	output logic                     softShutReq
);
	localparam int OVC = OVP_CYC;
	localparam int UVC = UVP_CYC;

	function automatic logic [8:0] adcCode(input logic [21:0] uv);
		logic [21:0] q;
		q = uv / ADC_LSB_UV;
		adcCode = (q > 22'(ADC_MAX_CODE)) ? ADC_MAX_CODE : q[8:0];
	endfunction

	function automatic logic [8:0] pctOf(input logic [8:0] pk,
		input logic [1:0] sel);
		logic [15:0] p;
		p = 16'(pk) * (16'd100 - 16'(sel) * 16'd10);
		pctOf = 9'(p / 16'd100);
	endfunction

	// Registers
	logic [8:0]         peakLimit_ff;
	logic [1:0]         pctSel_ff;
	logic [15:0]        trigDelay_ff;
	logic [15:0]        actDelay_ff;
	logic signed [13:0] initOfs_ff;
	logic               enPrev_ff;
	logic               initOfsEn_ff;
	nrfp_strap_s        strap_ff;
	logic [8:0]         ioutCode_ff;
	logic [7:0]         ovCnt_ff;
	logic [9:0]         uvCnt_ff;
	logic [9:0]         lockCnt_ff;
	logic               ovpLatch_ff;
	logic               uvpLatch_ff;
	logic               lockout_ff;
	logic               nvActive_ff;
	logic               softStop_ff;
	logic [15:0]        sustCnt_ff;
	logic [15:0]        actCnt_ff;
	nrfp_oc_e           ocState_ff;
	nrfp_oc_e           nxt_ocState;
	logic [7:0]         qrCnt_ff;

	// Decode
	wire         enRise   = railEnable & ~enPrev_ff;
	wire         apbWrite = psel & penable & pready & pwrite;
	wire         apbSetup = psel & ~penable;
	wire         hitCtrl  = paddr == ADDR_CTRL;
	wire         hitTim   = paddr == ADDR_TIMING;
	wire         hitIni   = paddr == ADDR_INIOFS;
	wire         hitStat  = paddr == ADDR_STATUS;
	wire         hitIout  = paddr == ADDR_IOUT;
	wire         hitOfs   = paddr == ADDR_OFFSET;
	wire         mapped   = hitCtrl | hitTim | hitIni | hitStat
		| hitIout | hitOfs;
	wire [31:0]  statWord = {25'h0, softStop_ff, nvActive_ff,
		lockout_ff, ocState_ff == OC_SHUT, uvpLatch_ff,
		ovpLatch_ff, ~overcurrentIndicator_n};
	wire [31:0]  rdMux    =
		hitCtrl ? {21'h0, pctSel_ff, peakLimit_ff} :
		hitTim  ? {actDelay_ff, trigDelay_ff} :
		hitIni  ? 32'(unsigned'(initOfs_ff)) :
		hitStat ? statWord :
		hitIout ? {23'h0, ioutCode_ff} :
		hitOfs  ? 32'(unsigned'(targetOffsetMv)) : 32'h0;

	wire [8:0]   sustLimit = pctOf(peakLimit_ff, pctSel_ff);
	wire         overSust  = ioutCode_ff > sustLimit;
	wire         sustTrip  = overSust
		& (sustCnt_ff >= trigDelay_ff);
	wire         peakTrip  = ioutCode_ff > peakLimit_ff;
	wire         anyTrip   = sustTrip | peakTrip;

	wire signed [13:0] ovThr = (targetMv < OVP_FLOOR_MV)
		? 14'(OVP_FLOOR_MV + OVP_MARG_MV)
		: 14'(targetMv + OVP_MARG_MV);
	wire signed [13:0] uvThr = 14'(targetMv - UVP_MARG_MV);
	wire         ovAbove  = senseMv > ovThr;
	wire         uvBelow  = railEnable & (senseMv < uvThr);
	wire signed [13:0] extOfs = 14'(offsetPinMv - EXT_BASE_MV
		+ (initOfsEn_ff ? initOfs_ff : 14'sd0));

	wire         cutAll = lockout_ff | uvpLatch_ff | ~railEnable
		| ocState_ff == OC_SHUT | softStop_ff;
	wire         qrOn   = qrCnt_ff != 8'h00;
	nrfp_gate_s  nxt_gate;
	always_comb begin
		nxt_gate = '0;
		if (cutAll) begin
			nxt_gate = '0;
		end else if (ovpLatch_ff) begin
			nxt_gate.low = ~nvActive_ff;
		end else begin
			nxt_gate.high = onTimeReq | qrOn;
			nxt_gate.low  = ~nxt_gate.high
				& (forceCcm | lowSideReq);
		end
	end

	always_comb begin
		nxt_ocState = ocState_ff;
		unique case (ocState_ff)
			OC_IDLE: if (anyTrip) begin
				nxt_ocState = OC_WAIT;
			end
			OC_WAIT: if (actCnt_ff >= actDelay_ff) begin
				nxt_ocState = overSust ? OC_SHUT : OC_IDLE;
			end
			OC_SHUT: nxt_ocState = OC_SHUT;
			default: nxt_ocState = OC_IDLE;
		endcase
		if (enRise) begin
			nxt_ocState = OC_IDLE;
		end
	end

	// Bus slave: one wait-free access phase after each setup
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= apbSetup;
			prdata  <= (apbSetup & ~pwrite) ? rdMux : 32'h0;
			pslverr <= apbSetup & ~mapped;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			peakLimit_ff <= RST_PEAK;
			pctSel_ff    <= RST_PCT;
			trigDelay_ff <= RST_TRIG;
			actDelay_ff  <= RST_ACT;
			initOfs_ff   <= RST_INIOF;
		end else if (ce && apbWrite) begin
			if (hitCtrl) begin
				peakLimit_ff <= pwdata[CTRL_PEAK_LSB +: 9];
				pctSel_ff    <= pwdata[CTRL_PCT_LSB +: 2];
			end
			if (hitTim) begin
				trigDelay_ff <= pwdata[TIM_TRIG_LSB +: 16];
				actDelay_ff  <= pwdata[TIM_ACT_LSB +: 16];
			end
			if (hitIni) begin
				initOfs_ff <= pwdata[13:0];
			end
		end
	end

	// Straps and the offset pin threshold test are caught at the enable edge; extOfs follows the pin live
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			enPrev_ff    <= 1'b0;
			initOfsEn_ff <= 1'b0;
			strap_ff     <= '0;
		end else if (ce) begin
			enPrev_ff <= railEnable;
			if (enRise) begin
				initOfsEn_ff <= offsetPinMv >= OFS_OFF_MV;
				strap_ff     <= strapPins;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			targetOffsetMv <= 14'sd0;
			slewCompBits   <= 4'h0;
			rampSel        <= 3'h0;
			ioutCode_ff    <= 9'h000;
		end else if (ce) begin
			targetOffsetMv <= strap_ff.two[STRAP_EXT_BIT] ? extOfs
				: (initOfsEn_ff ? initOfs_ff : 14'sd0);
			slewCompBits   <= {strap_ff.two[1:0],
				strap_ff.one[1:0]};
			rampSel        <= strap_ff.one;
			ioutCode_ff    <= adcCode(currentMonUv);
		end
	end

	// Downward change has no term here, so the mode is held
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			forceCcm <= 1'b0;
		end else if (ce) begin
			if (dvidUp) begin
				forceCcm <= 1'b1;
			end else if (dvidDone) begin
				forceCcm <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			qrCnt_ff <= 8'h00;
		end else if (ce) begin
			if (qrTrigger) begin
				qrCnt_ff <= onTimeLen;
			end else if (qrOn) begin
				qrCnt_ff <= qrCnt_ff - 8'h01;
			end
		end
	end

	// Peak limit is compared every cycle so a spike inside any
	// switching cycle trips; cycleStart is not needed for that
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sustCnt_ff <= 16'h0;
			actCnt_ff  <= 16'h0;
			ocState_ff <= OC_IDLE;
			overcurrentIndicator_n <= 1'b1;
		end else if (ce) begin
			sustCnt_ff <= !overSust ? 16'h0
				: (sustCnt_ff == 16'hffff) ? sustCnt_ff
				: sustCnt_ff + 16'h1;
			actCnt_ff  <= (ocState_ff == OC_WAIT)
				? actCnt_ff + 16'h1 : 16'h0;
			ocState_ff <= nxt_ocState;
			overcurrentIndicator_n <= nxt_ocState == OC_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ovCnt_ff    <= 8'h00;
			ovpLatch_ff <= 1'b0;
			nvActive_ff <= 1'b0;
		end else if (ce) begin
			ovCnt_ff <= ovAbove ? ((ovCnt_ff == 8'(OVC - 1))
				? ovCnt_ff : ovCnt_ff + 8'h01) : 8'h00;
			if (ovAbove && ovCnt_ff == 8'(OVC - 1)) begin
				ovpLatch_ff <= 1'b1;
			end else if (enRise) begin
				ovpLatch_ff <= 1'b0;
			end
			if (!ovpLatch_ff || enRise) begin
				nvActive_ff <= 1'b0;
			end else if (senseMv < NV_LEVEL_MV) begin
				nvActive_ff <= 1'b1;
			end else if (senseMv > NV_LEVEL_MV) begin
				nvActive_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			uvCnt_ff    <= 10'h000;
			uvpLatch_ff <= 1'b0;
		end else if (ce) begin
			uvCnt_ff <= uvBelow ? ((uvCnt_ff == 10'(UVC - 1))
				? uvCnt_ff : uvCnt_ff + 10'h001) : 10'h000;
			if (uvBelow && uvCnt_ff == 10'(UVC - 1)) begin
				uvpLatch_ff <= 1'b1;
			end else if (enRise) begin
				uvpLatch_ff <= 1'b0;
			end
		end
	end

	// Lockout follows the supply: it lifts as soon as supply is good
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lockCnt_ff <= 10'h000;
			lockout_ff <= 1'b0;
		end else if (ce) begin
			lockCnt_ff <= supplyLow ? ((lockCnt_ff
				== 10'(LOCK_CYC - 1)) ? lockCnt_ff
				: lockCnt_ff + 10'h001) : 10'h000;
			lockout_ff <= supplyLow
				& (lockCnt_ff == 10'(LOCK_CYC - 1));
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			softStop_ff <= 1'b0;
			softShutReq <= 1'b0;
			gateDrive   <= '0;
		end else if (ce) begin
			if (otherRailFault) begin
				softStop_ff <= 1'b1;
			end else if (enRise) begin
				softStop_ff <= 1'b0;
			end
			softShutReq <= ovpLatch_ff | uvpLatch_ff;
			gateDrive   <= nxt_gate;
		end
	end

	// Checks assume ce high across their span
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n || !ce);

	AST_OVP_DELAY: assert property (
		$rose(ovpLatch_ff) |-> $past(ovAbove)
			&& $past(ovCnt_ff) == 8'(OVC - 1))
		else $error("overvoltage latched without full delay");
	AST_OVP_GATES: assert property (
		ovpLatch_ff && !nvActive_ff && !cutAll
			|=> gateDrive.low && !gateDrive.high)
		else $error("overvoltage drive wrong");
	AST_NVP_ONLY_OVP: assert property (
		nvActive_ff && !cutAll |-> ovpLatch_ff ##1 !gateDrive.low)
		else $error("negative guard outside overvoltage");
	AST_UV_CUT: assert property (
		uvpLatch_ff |=> gateDrive == '0)
		else $error("undervoltage did not cut switches");
	AST_LOCK_CUT: assert property (
		supplyLow [*8] ##0 lockout_ff |=> gateDrive == '0)
		else $error("lockout did not cut switches");
	AST_OC_IND: assert property (
		anyTrip && ocState_ff == OC_IDLE && !enRise
			|=> !overcurrentIndicator_n && ocState_ff == OC_WAIT)
		else $error("indicator late on trip");
	AST_DVID_UP: assert property (
		dvidUp |=> forceCcm [*2] or (forceCcm ##1 $past(dvidDone)))
		else $error("upward change did not force mode");
	AST_DVID_DOWN: assert property (
		dvidDown && !dvidUp && !dvidDone |=> $stable(forceCcm))
		else $error("downward change altered mode");
	AST_SOFT: assert property (
		$rose(uvpLatch_ff) || $rose(ovpLatch_ff) |=> softShutReq)
		else $error("no soft shutdown request");
	AST_ADC: assert property (
		ioutCode_ff <= ADC_MAX_CODE ##1
			ioutCode_ff == adcCode($past(currentMonUv)))
		else $error("current code mismatch");
	AST_QR: assert property (
		qrTrigger && onTimeLen != 8'h00 && !cutAll && !ovpLatch_ff
			|=> ##1 gateDrive.high)
		else $error("fast pulse did not drive high side");

	COV_OVP: cover property ($rose(ovpLatch_ff));
	COV_NVP: cover property ($rose(nvActive_ff));
	COV_OCSHUT: cover property (ocState_ff == OC_SHUT);
	COV_OCREL: cover property (ocState_ff == OC_WAIT ##1
		ocState_ff == OC_IDLE);
endmodule

// ### test/nb_rail_fault_protect_monitor_bench.sv
`timescale 1ns/1ps
module nb_rail_fault_protect_monitor_bench;
	import nrfp_pkg::*;
	logic clk, reset_n, ce, psel, penable, pwrite, pready, pslverr, rdErr;
	logic [7:0]  paddr, onTimeLen;
	logic [31:0] pwdata, prdata, rdData;
	logic railEnable, supplyLow, otherRailFault, dvidUp, dvidDown, dvidDone;
	logic qrTrigger, onTimeReq, lowSideReq, forceCcm, softShutReq, ocInd_n;
	logic signed [13:0] offsetPinMv, targetMv, senseMv, levelMv, sinkMv;
	logic signed [13:0] targetOffsetMv, ini, pin;
	logic [21:0] currentMonUv, uv;
	nrfp_strap_s strapPins;
	nrfp_gate_s  gateDrive;
	logic [3:0]  slewCompBits;
	logic [2:0]  rampSel;
	logic [21:0] corner [4] = '{22'h001869, 22'h00186a, 22'h30bb96, 22'h3fffff};
	int failures, checks_done, seed, i, n;

	nrfp_rail_monitor dut (.clk(clk), .reset_n(reset_n), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.railEnable(railEnable), .strapPins(strapPins),
		.offsetPinMv(offsetPinMv), .targetMv(targetMv), .senseMv(senseMv),
		.currentMonUv(currentMonUv), .supplyLow(supplyLow),
		.otherRailFault(otherRailFault), .dvidUp(dvidUp),
		.dvidDown(dvidDown), .dvidDone(dvidDone), .qrTrigger(qrTrigger),
		.onTimeLen(onTimeLen), .onTimeReq(onTimeReq),
		.lowSideReq(lowSideReq), .cycleStart(1'b0), .gateDrive(gateDrive),
		.overcurrentIndicator_n(ocInd_n), .forceCcm(forceCcm),
		.slewCompBits(slewCompBits), .rampSel(rampSel),
		.targetOffsetMv(targetOffsetMv), .softShutReq(softShutReq));
	nrfp_stage_model stage (.clk(clk), .gate(gateDrive), .levelMv(levelMv),
		.sinkMv(sinkMv), .senseMv(senseMv));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [8:0] adcCode(input logic [21:0] v);
		return (v / ADC_LSB_UV > 22'h0001ff) ? ADC_MAX_CODE : 9'(v / ADC_LSB_UV);
	endfunction

	function automatic logic signed [13:0] ofsExp(input logic signed [13:0] p,
		input logic signed [13:0] io, input logic ext);
		return (ext ? p - EXT_BASE_MV : 14'sh0000) +
			(p >= OFS_OFF_MV ? io : 14'sh0000);
	endfunction

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Starts just after an edge; one idle cycle after each transfer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk("pready", 32'h1, {31'h0, pready});
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic ena();
		railEnable <= 1'b0;
		cyc(2);
		railEnable <= 1'b1;
		cyc(3);
	endtask

	task automatic dv(input logic [2:0] v);
		{dvidUp, dvidDown, dvidDone} <= v;
		cyc(1);
		{dvidUp, dvidDown, dvidDone} <= 3'h0;
		cyc(2);
	endtask

	task automatic volts(input logic signed [13:0] lv, input logic signed [13:0] sk);
		levelMv <= lv;
		sinkMv <= sk;
	endtask

	task automatic waitLow(input logic v);
		n = 0;
		while (gateDrive.low !== v && n < 200) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#100000;
		failures++;
		print_verdict();
	end

	initial begin
		seed = 22081;
		{reset_n, psel, penable, pwrite, railEnable, supplyLow} = 6'h00;
		{otherRailFault, dvidUp, dvidDown, dvidDone, qrTrigger} = 5'h00;
		{onTimeReq, lowSideReq, paddr, pwdata, strapPins} = 48'h0;
		{offsetPinMv, targetMv, levelMv, sinkMv, currentMonUv} = 78'h0;
		ce = 1'b1;
		onTimeLen = 8'h08;
		cyc(2);
		reset_n <= 1'b1;
		cyc(1);
		chk("gate", 32'h0, 32'(gateDrive));
		chk("ocInd", 32'h1, {31'h0, ocInd_n});
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", {21'h0, RST_PCT, RST_PEAK}, rdData);
		apb(1'b0, ADDR_TIMING, 32'h0);
		chk("timing", {RST_ACT, RST_TRIG}, rdData);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h1, {31'h0, rdErr});
		$display("test registers done");
		for (i = 0; i < 12; i++) begin
			uv = i < 4 ? corner[i] : 22'($unsigned($random(seed)) % 3400000);
			currentMonUv <= uv;
			cyc(3);
			apb(1'b0, ADDR_IOUT, 32'h0);
			chk("iout", {23'h0, adcCode(uv)}, rdData);
		end
		currentMonUv <= 22'h0;
		$display("test current code done");
		for (i = 0; i < 6; i++) begin
			ini = 14'($signed(10'($random(seed))));
			pin = i == 0 ? 14'sh00fa : i == 1 ? 14'sh012c : i == 2 ? 14'sh0514
				: 14'($unsigned($random(seed)) % 2048);
			apb(1'b1, ADDR_INIOFS, {18'h0, ini});
			strapPins <= 6'($random(seed));
			offsetPinMv <= pin;
			ena();
			chk("ramp", 32'(strapPins.one), 32'(rampSel));
			chk("slew", {28'h0, strapPins.two[1:0], strapPins.one[1:0]},
				32'(slewCompBits));
			chk("offset", 32'(ofsExp(pin, ini, strapPins.two[STRAP_EXT_BIT])),
				32'(targetOffsetMv));
		end
		$display("test offsets done");
		dv(3'h4);
		chk("ccmUp", 32'h1, {31'h0, forceCcm});
		chk("ccmLow", 32'h1, 32'(gateDrive));
		dv(3'h2);
		chk("ccmDownHold", 32'h1, {31'h0, forceCcm});
		ce <= 1'b0;
		dv(3'h1);
		chk("ceFreeze", 32'h1, {31'h0, forceCcm});
		ce <= 1'b1;
		dv(3'h1);
		dv(3'h2);
		chk("ccmDownKeep", 32'h0, {31'h0, forceCcm});
		qrTrigger <= 1'b1;
		cyc(1);
		qrTrigger <= 1'b0;
		n = 0;
		repeat (20) begin
			@(negedge clk);
			n += gateDrive.high;
		end
		@(posedge clk);
		chk("qrWidth", 32'h1, {31'h0, n >= 7 && n <= 9});
		$display("test transient done");
		apb(1'b1, ADDR_CTRL, 32'h00000264);
		apb(1'b1, ADDR_TIMING, 32'h001e0014);
		onTimeReq <= 1'b1;
		currentMonUv <= 22'h090fba;
		cyc(12);
		chk("ocEarly", 32'h1, {31'h0, ocInd_n});
		cyc(20);
		chk("ocSust", 32'h0, {31'h0, ocInd_n});
		currentMonUv <= 22'h04c4b4;
		cyc(50);
		chk("ocClear", 32'h1, {31'h0, ocInd_n});
		chk("gateKept", 32'h1, {31'h0, gateDrive.high});
		currentMonUv <= 22'h0e4e1c;
		cyc(3);
		chk("ocPeak", 32'h0, {31'h0, ocInd_n});
		cyc(40);
		chk("ocShut", 32'h0, 32'(gateDrive));
		currentMonUv <= 22'h0;
		cyc(10);
		chk("ocLatched", 32'h0, 32'(gateDrive));
		ena();
		chk("ocRelease", 32'h1, {31'h0, gateDrive.high});
		$display("test overcurrent done");
		onTimeReq <= 1'b0;
		targetMv <= 14'sh02bc;
		volts(14'sh044c, 14'sh044c);
		cyc(300);
		chk("ovFloor", 32'h0, {31'h0, softShutReq});
		volts(14'sh04e2, 14'sh04e2);
		cyc(150);
		chk("ovEarly", 32'h0, {31'h0, softShutReq});
		cyc(80);
		chk("ovGate", 32'h1, 32'(gateDrive));
		chk("ovShut", 32'h1, {31'h0, softShutReq});
		volts(14'sh0064, 14'sh3f9c);
		waitLow(1'b0);
		chk("nvOff", 32'h0, 32'(gateDrive));
		waitLow(1'b1);
		chk("nvOn", 32'h1, 32'(gateDrive));
		ena();
		chk("ovRelease", 32'h0, {31'h0, softShutReq});
		$display("test overvoltage done");
		onTimeReq <= 1'b1;
		targetMv <= 14'sh03e8;
		volts(14'sh03e8, 14'sh03e8);
		cyc(60);
		volts(14'sh0190, 14'sh0190);
		cyc(550);
		chk("uvEarly", 32'h1, {31'h0, gateDrive.high});
		cyc(100);
		chk("uvGate", 32'h0, 32'(gateDrive));
		chk("uvShut", 32'h1, {31'h0, softShutReq});
		volts(14'sh03e8, 14'sh03e8);
		cyc(60);
		ena();
		otherRailFault <= 1'b1;
		cyc(5);
		chk("otherRail", 32'h0, 32'(gateDrive));
		otherRailFault <= 1'b0;
		ena();
		$display("test undervoltage done");
		supplyLow <= 1'b1;
		cyc(550);
		chk("lockEarly", 32'h1, {31'h0, gateDrive.high});
		cyc(100);
		chk("lockGate", 32'h0, 32'(gateDrive));
		supplyLow <= 1'b0;
		cyc(3);
		chk("lockLift", 32'h1, {31'h0, gateDrive.high});
		$display("test lockout done");
		print_verdict();
	end
endmodule

// ### test/nrfp_stage_model.sv
`timescale 1ns/1ps
module nrfp_stage_model
	import nrfp_pkg::*;
(
	input  wire logic               clk,
	input  wire nrfp_gate_s         gate,
	input  wire logic signed [13:0] levelMv,
	input  wire logic signed [13:0] sinkMv,
	output logic signed [13:0]      senseMv
);
	// Output moves at a finite slew, so no protection sees an instant jump
	logic signed [13:0] aimMv;
	assign aimMv = gate.low ? sinkMv : levelMv;
	initial senseMv = 14'sh0000;
	always @(posedge clk) begin
		if (senseMv < aimMv - 14'sh0019)
			senseMv <= senseMv + 14'sh0019;
		else if (senseMv > aimMv + 14'sh0019)
			senseMv <= senseMv - 14'sh0019;
		else
			senseMv <= aimMv;
	end
endmodule
